// [design/pcc_pkg.sv]
// Purpose: Shared constants and types for the pulse channel comparator board logic
// Assumes: 20 MHz clock, byte addressed register port with 8-bit address
// Notes:   Long cycle counts are also top-level parameters so simulation can shorten them
package pcc_pkg;
    localparam int NCH     = 5;
    localparam int NPAIR   = 2;
    localparam int MODE_W  = 3;
    localparam int THR_W   = 4;
    localparam int CNT_W   = 16;
    localparam int PEND_W  = 8;
    localparam int ADDR_W  = 8;
    localparam int IRQ_W   = 4;

    localparam int CLK_HZ         = 20_000_000;
    localparam int DEB_US         = 50_000;
    localparam int DEB_CYC        = DEB_US * (CLK_HZ / 1_000_000);
    localparam int DEB_W          = 20;
    localparam int TICK_US        = 1_000;
    localparam int TICK_CYC       = TICK_US * (CLK_HZ / 1_000_000);
    localparam int TICK_W         = 15;
    localparam int REFRESH_MS     = 1_000;
    localparam int REFRESH_CYC    = REFRESH_MS * (CLK_HZ / 1_000);
    localparam int REFRESH_W      = 25;
    localparam int PULSE_HALF_US  = 62_500;
    localparam int PULSE_HALF_CYC = PULSE_HALF_US * (CLK_HZ / 1_000_000);
    localparam int PULSE_W        = 21;

    // Mode switch field layout, per channel
    localparam int MF_MODE_LSB = 0;
    localparam int MF_DEB      = 2;

    localparam logic [ADDR_W-1:0] ADDR_ID       = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MODE     = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_THRESH   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STAT_OUT = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_IN_LEVEL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_CUTOFF   = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_CMP_STAT = 8'h20;
    localparam logic [2:0]        PAGE_PEND     = 3'h2;
    localparam logic [2:0]        PAGE_TOTAL    = 3'h3;

    localparam int IRQ_ALARM_LSB = 0;
    localparam int IRQ_DIR_LSB   = 2;
    localparam int ID_FIT_POS    = 8;
    localparam int ID_NCH_LSB    = 12;
    localparam int CS_SLOW_LSB   = 2;
    localparam int CS_EN_LSB     = 4;

    localparam logic [15:0]      CUTOFF_RST   = 16'h03e8;
    localparam logic [IRQ_W-1:0] MASK_RST     = 4'h0;
    localparam logic [NCH-1:0]   STAT_OUT_RST = 5'h00;
    // Arbitrary card type code
    localparam logic [7:0]       CARD_TYPE    = 8'h3c;
    localparam logic [3:0]       NCH_CODE     = 4'h5;

    typedef enum logic [1:0] {
        MODE_STAT_IN   = 2'h0,
        MODE_PULSE_IN  = 2'h1,
        MODE_STAT_OUT  = 2'h2,
        MODE_PULSE_OUT = 2'h3
    } pcc_mode_t;
endpackage

// [design/pcc_pair_if.sv]
// Purpose: Carrier between the top and one pair comparator
// Assumes: Single clock domain
// Notes:   Edges are one-cycle pulses from the input conditioners
`timescale 1ns/100ps
interface pcc_pair_if;
    logic        a_edge;
    logic        b_edge;
    logic        b_lvl;
    logic        enable;
    logic [15:0] cutoff;
    logic        err;
    logic        dir;
    logic        slow;
    modport cmp (input a_edge, b_edge, b_lvl, enable, cutoff, output err, dir, slow);
    modport top (output a_edge, b_edge, b_lvl, enable, cutoff, input err, dir, slow);
endinterface

// [design/pcc_chan_in.sv]
// Purpose: Input conditioner for one channel: synchroniser, debounce, rising edge
// Assumes: Pin is asynchronous to i_clock
// Notes:   Debounce path needs the level stable for DEB_CYCLES before it is accepted
`timescale 1ns/100ps
module pcc_chan_in #(
    parameter int DEB_CYCLES = pcc_pkg::DEB_CYC
) (
    input  wire logic i_clock,
    input  wire logic i_arst_n,
    input  wire logic i_pin,
    input  wire logic i_debounce,
    output logic      o_level,
    output logic      o_rise
);
    import pcc_pkg::*;

    logic              s1_reg;
    logic              s2_reg;
    logic              s3_reg;
    logic              clean_reg;
    logic              filt_reg;
    logic              rise_reg;
    logic [DEB_W-1:0]  deb_cnt_reg;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            clean_reg <= 1'b0;
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                clean_reg <= s3_reg;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            filt_reg    <= 1'b0;
            deb_cnt_reg <= '0;
        end else if (!i_debounce || clean_reg == filt_reg) begin
            filt_reg    <= i_debounce ? filt_reg : clean_reg;
            deb_cnt_reg <= '0;
        end else if (deb_cnt_reg == DEB_W'(DEB_CYCLES - 1)) begin
            filt_reg    <= clean_reg;
            deb_cnt_reg <= '0;
        end else begin
            deb_cnt_reg <= deb_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rise_reg <= 1'b0;
            o_level  <= 1'b0;
        end else begin
            o_level  <= filt_reg;
            rise_reg <= filt_reg & ~o_level;
        end
    end

    assign o_rise = rise_reg;
endmodule // pcc_chan_in

// [design/pcc_cmp.sv]
// Purpose: Pulse comparator and phase discriminator for one channel pair
// Assumes: Edge pulses are one cycle long and already synchronised
// Notes:   Cutoff counts whole milliseconds between A edges
`timescale 1ns/100ps
module pcc_cmp #(
    parameter int TICK_CYCLES = pcc_pkg::TICK_CYC
) (
    input  wire logic i_clock,
    input  wire logic i_arst_n,
    pcc_pair_if.cmp   bus
);
    import pcc_pkg::*;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_A    = 3'b010,
        SEQ_B    = 3'b100
    } pcc_seq_t;

    pcc_seq_t            seq_reg;
    logic [TICK_W-1:0]   tick_cnt_reg;
    logic [15:0]         period_reg;
    logic                slow_reg;
    logic                err_reg;
    logic                dir_reg;
    logic                tick;
    logic                bad;

    assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
    // Both edges together, or two edges in a row from one side
    assign bad = (bus.a_edge & bus.b_edge)
               | (bus.a_edge & (seq_reg == SEQ_A))
               | (bus.b_edge & (seq_reg == SEQ_B));

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    // Saturating period in ms since the last A edge
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            period_reg <= 16'hffff;
            slow_reg   <= 1'b1;
        end else begin
            if (bus.a_edge) begin
                period_reg <= '0;
            end else if (tick && period_reg != 16'hffff) begin
                period_reg <= period_reg + 1'b1;
            end
            if (!bus.enable) begin
                slow_reg <= 1'b1;
            end else if (bus.a_edge) begin
                slow_reg <= (period_reg >= bus.cutoff);
            end else if (period_reg >= bus.cutoff) begin
                slow_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            unique case ({bus.a_edge, bus.b_edge})
                2'b11: seq_reg <= SEQ_IDLE;
                2'b10: seq_reg <= SEQ_A;
                2'b01: seq_reg <= SEQ_B;
                2'b00: seq_reg <= seq_reg;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= bus.enable & ~slow_reg & bad;
        end
    end

    // B low at an A rise means A leads by a quarter period
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dir_reg <= 1'b0;
        end else if (bus.enable && !slow_reg && bus.a_edge) begin
            dir_reg <= ~bus.b_lvl;
        end
    end

    assign bus.err  = err_reg;
    assign bus.dir  = dir_reg;
    assign bus.slow = slow_reg;
endmodule // pcc_cmp

// [design/pcc_top.sv]
// Purpose: Five channel digital I/O board with pair comparators and register port
// Assumes: Switch and strap inputs are static; register master follows the plain strobe port
// Notes:   Configuration straps are taken once after reset release
`timescale 1ns/100ps
// How it works
// - Five channels, each in one of four modes
// - Mode comes from captured static switches
// - Pairs 1/2 and 3/4 compare when fitted
// - Check count, frequency, phase and order continuously
// - Simultaneous pulses on a pair are errors
// - Any comparison error latches an alarm
// - Below programmable cutoff, errors are suppressed
// - Pairs report flow direction from two pickups
// - Quadrature trains resolved; leading input found
// - Discriminator pairs inputs 1/2 and 3/4
// - Totalizer counts every pulse up to 10 kHz
// - Measurements refreshed well within five seconds
// - Pulse output at most 8/s, half duty
// - Presence, type and configuration are readable
// - Debounced or full-bandwidth input, per channel
module pcc_top #(
    parameter int DEB_CYCLES        = pcc_pkg::DEB_CYC,
    parameter int TICK_CYCLES       = pcc_pkg::TICK_CYC,
    parameter int REFRESH_CYCLES    = pcc_pkg::REFRESH_CYC,
    parameter int PULSE_HALF_CYCLES = pcc_pkg::PULSE_HALF_CYC
) (
    input  wire logic                                      i_clock,
    input  wire logic                                      i_arst_n,
    input  wire logic [pcc_pkg::ADDR_W-1:0]                i_addr,
    input  wire logic [31:0]                               i_wdata,
    input  wire logic                                      i_wr,
    input  wire logic                                      i_rd,
    output logic      [31:0]                               o_rdata,
    input  wire logic [pcc_pkg::NCH*pcc_pkg::MODE_W-1:0]   i_channel_mode_switches,
    input  wire logic [pcc_pkg::NCH*pcc_pkg::THR_W-1:0]    i_channel_threshold_switches,
    input  wire logic                                      i_cmp_fitted,
    input  wire logic [pcc_pkg::NCH-1:0]                   i_chan_pin,
    output logic      [pcc_pkg::NCH-1:0]                   o_chan_out,
    output logic      [pcc_pkg::NCH-1:0]                   o_chan_oe,
    output logic                                           o_irq
);
    import pcc_pkg::*;

    localparam int MSW_W = NCH * MODE_W;
    localparam int TSW_W = NCH * THR_W;
    localparam int CFG_W = MSW_W + TSW_W + 1;

    logic [CFG_W-1:0]      cfg_s1_reg;
    logic [CFG_W-1:0]      cfg_s2_reg;
    logic [CFG_W-1:0]      cfg_s3_reg;
    logic [CFG_W-1:0]      cfg_reg;
    logic                  cfg_done_reg;
    pcc_mode_t             mode [NCH];
    logic [NCH-1:0]        deb;
    logic [NCH-1:0]        lvl;
    logic [NCH-1:0]        rise;
    logic [NPAIR-1:0]      err;
    logic [NPAIR-1:0]      dir;
    logic [NPAIR-1:0]      slow;
    logic [NPAIR-1:0]      pen;
    logic [NPAIR-1:0]      dir_prev_reg;
    logic [15:0]           cutoff_reg;
    logic [NCH-1:0]        stat_out_reg;
    logic [IRQ_W-1:0]      irq_stat_reg;
    logic [IRQ_W-1:0]      irq_mask_reg;
    logic [IRQ_W-1:0]      irq_event;
    logic [IRQ_W-1:0]      irq_clear;
    logic [CNT_W-1:0]      total_reg [NCH];
    logic [CNT_W-1:0]      snap_reg  [NCH];
    logic [PEND_W-1:0]     pend_reg  [NCH];
    logic [NCH-1:0]        pulse_on_reg;
    logic [REFRESH_W-1:0]  refresh_cnt_reg;
    logic                  refresh_now;
    logic [PULSE_W-1:0]    pulse_cnt_reg;
    logic                  pulse_phase_reg;
    logic                  half_end;
    logic                  period_start;
    logic [2:0]            page;
    logic [2:0]            idx;
    logic                  idx_ok;
    logic [31:0]           rd_mux;

    assign page   = i_addr[7:5];
    assign idx    = i_addr[4:2];
    assign idx_ok = (idx < 3'(NCH));

    // Unequal reset values stop a capture before straps arrive
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_s1_reg   <= '0;
            cfg_s2_reg   <= '1;
            cfg_s3_reg   <= '0;
            cfg_reg      <= '0;
            cfg_done_reg <= 1'b0;
        end else begin
            cfg_s1_reg <= {i_cmp_fitted, i_channel_threshold_switches, i_channel_mode_switches};
            cfg_s2_reg <= cfg_s1_reg;
            cfg_s3_reg <= cfg_s2_reg;
            if (!cfg_done_reg && cfg_s2_reg == cfg_s3_reg) begin
                cfg_reg      <= cfg_s3_reg;
                cfg_done_reg <= 1'b1;
            end
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_chan
        assign mode[c] = pcc_mode_t'(cfg_reg[c*MODE_W+MF_MODE_LSB +: 2]);
        assign deb[c]  = cfg_reg[c*MODE_W+MF_DEB];
        pcc_chan_in #(
            .DEB_CYCLES (DEB_CYCLES)
        ) u_in (
            .i_clock    (i_clock),
            .i_arst_n   (i_arst_n),
            .i_pin      (i_chan_pin[c]),
            .i_debounce (deb[c]),
            .o_level    (lvl[c]),
            .o_rise     (rise[c])
        );
    end

    pcc_pair_if pair_if [NPAIR] ();

    for (genvar p = 0; p < NPAIR; p++) begin : g_pair
        assign pen[p] = cfg_reg[CFG_W-1] & (mode[2*p] == MODE_PULSE_IN)
                      & (mode[2*p+1] == MODE_PULSE_IN);
        assign pair_if[p].a_edge = rise[2*p];
        assign pair_if[p].b_edge = rise[2*p+1];
        assign pair_if[p].b_lvl  = lvl[2*p+1];
        assign pair_if[p].enable = pen[p];
        assign pair_if[p].cutoff = cutoff_reg;
        assign err[p]  = pair_if[p].err;
        assign dir[p]  = pair_if[p].dir;
        assign slow[p] = pair_if[p].slow;
        pcc_cmp #(
            .TICK_CYCLES (TICK_CYCLES)
        ) u_cmp (
            .i_clock  (i_clock),
            .i_arst_n (i_arst_n),
            .bus      (pair_if[p])
        );
    end

    // Interrupt status: alarms and direction changes, write one to clear
    assign irq_event = {dir ^ dir_prev_reg, err};
    assign irq_clear = (i_wr && i_addr == ADDR_IRQ_STAT) ? i_wdata[IRQ_W-1:0] : '0;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_stat_reg <= '0;
            dir_prev_reg <= '0;
            o_irq        <= 1'b0;
        end else begin
            dir_prev_reg <= dir;
            // Set beats clear, so a live error keeps the alarm
            irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_event;
            o_irq        <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_mask_reg <= MASK_RST;
            cutoff_reg   <= CUTOFF_RST;
            stat_out_reg <= STAT_OUT_RST;
        end else if (i_wr) begin
            if (i_addr == ADDR_IRQ_MASK) begin
                irq_mask_reg <= i_wdata[IRQ_W-1:0];
            end
            if (i_addr == ADDR_CUTOFF) begin
                cutoff_reg <= i_wdata[15:0];
            end
            if (i_addr == ADDR_STAT_OUT) begin
                stat_out_reg <= i_wdata[NCH-1:0];
            end
        end
    end

    // Totals wrap; host takes differences between snapshots
    assign refresh_now = (refresh_cnt_reg == REFRESH_W'(REFRESH_CYCLES - 1));

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            refresh_cnt_reg <= '0;
        end else begin
            refresh_cnt_reg <= refresh_now ? '0 : refresh_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int c = 0; c < NCH; c++) begin
                total_reg[c] <= '0;
                snap_reg[c]  <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (rise[c] && mode[c] == MODE_PULSE_IN) begin
                    total_reg[c] <= total_reg[c] + 1'b1;
                end
                if (refresh_now) begin
                    snap_reg[c] <= total_reg[c];
                end
            end
        end
    end

    // One shared 8 Hz frame: first half high, second half low
    assign half_end     = (pulse_cnt_reg == PULSE_W'(PULSE_HALF_CYCLES - 1));
    assign period_start = half_end & pulse_phase_reg;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pulse_cnt_reg   <= '0;
            pulse_phase_reg <= 1'b0;
        end else begin
            pulse_cnt_reg <= half_end ? '0 : pulse_cnt_reg + 1'b1;
            if (half_end) begin
                pulse_phase_reg <= ~pulse_phase_reg;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pulse_on_reg <= '0;
            for (int c = 0; c < NCH; c++) begin
                pend_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (period_start) begin
                    pulse_on_reg[c] <= (pend_reg[c] != '0) && (mode[c] == MODE_PULSE_OUT);
                end else if (half_end) begin
                    pulse_on_reg[c] <= 1'b0;
                end
                // Host load wins over the running decrement
                if (i_wr && page == PAGE_PEND && idx == 3'(c)) begin
                    pend_reg[c] <= i_wdata[PEND_W-1:0];
                end else if (period_start && pend_reg[c] != '0 && mode[c] == MODE_PULSE_OUT) begin
                    pend_reg[c] <= pend_reg[c] - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_chan_out <= '0;
            o_chan_oe  <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                o_chan_oe[c]  <= (mode[c] == MODE_STAT_OUT) || (mode[c] == MODE_PULSE_OUT);
                o_chan_out[c] <= ((mode[c] == MODE_STAT_OUT) & stat_out_reg[c])
                               | ((mode[c] == MODE_PULSE_OUT) & pulse_on_reg[c]);
            end
        end
    end

    always_comb begin
        rd_mux = '0;
        unique case (i_addr)
            ADDR_ID: begin
                rd_mux[7:0]                   = CARD_TYPE;
                rd_mux[ID_FIT_POS]            = cfg_reg[CFG_W-1];
                rd_mux[ID_NCH_LSB +: 4]       = NCH_CODE;
            end
            ADDR_MODE:     rd_mux[MSW_W-1:0] = cfg_reg[MSW_W-1:0];
            ADDR_THRESH:   rd_mux[TSW_W-1:0] = cfg_reg[MSW_W +: TSW_W];
            ADDR_STAT_OUT: rd_mux[NCH-1:0]   = stat_out_reg;
            ADDR_IN_LEVEL: rd_mux[NCH-1:0]   = lvl;
            ADDR_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_reg;
            ADDR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
            ADDR_CUTOFF:   rd_mux[15:0]      = cutoff_reg;
            ADDR_CMP_STAT: begin
                rd_mux[NPAIR-1:0]              = dir;
                rd_mux[CS_SLOW_LSB +: NPAIR]   = slow;
                rd_mux[CS_EN_LSB +: NPAIR]     = pen;
            end
            default: begin
                if (page == PAGE_PEND && idx_ok && i_addr[1:0] == 2'h0) begin
                    rd_mux[PEND_W-1:0] = pend_reg[idx];
                end else if (page == PAGE_TOTAL && idx_ok && i_addr[1:0] == 2'h0) begin
                    rd_mux[CNT_W-1:0] = snap_reg[idx];
                end
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? rd_mux : '0;
        end
    end
endmodule // pcc_top

// [dv/pcc_monitor.sv]
// Purpose: Port checker for pcc_top
// Assumes: Channel 4 strapped as pulse output; pulse half period set by parameter
// Notes:   Sees ports only, so alarm state is judged through o_irq
`timescale 1ns/100ps
module pcc_monitor #(
    parameter int PULSE_HALF_CYCLES = 16
) (
    input  wire logic                                    i_clock,
    input  wire logic                                    i_arst_n,
    input  wire logic [pcc_pkg::ADDR_W-1:0]              i_addr,
    input  wire logic                                    i_wr,
    input  wire logic                                    i_rd,
    input  wire logic [31:0]                             o_rdata,
    input  wire logic [pcc_pkg::NCH*pcc_pkg::MODE_W-1:0] i_channel_mode_switches,
    input  wire logic                                    i_cmp_fitted,
    input  wire logic [pcc_pkg::NCH-1:0]                 o_chan_out,
    input  wire logic [pcc_pkg::NCH-1:0]                 o_chan_oe,
    input  wire logic                                    o_irq
);
    import pcc_pkg::*;
    localparam int PH8 = PULSE_HALF_CYCLES - 8;
    logic [3:0] up_cnt_reg;
    logic [4:0] mode_oe;
    // Output modes are the ones with mode bit 1 set
    assign mode_oe = {i_channel_mode_switches[13], i_channel_mode_switches[10], i_channel_mode_switches[7],
                      i_channel_mode_switches[4], i_channel_mode_switches[1]};
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            up_cnt_reg <= 4'h0;
        else if (up_cnt_reg != 4'hf)
            up_cnt_reg <= up_cnt_reg + 4'h1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    sequence pulse_hi_s;
        o_chan_out[4] [*8] ##PH8 o_chan_out[4] ##1 !o_chan_out[4];
    endsequence
    sequence pulse_lo_s;
        !o_chan_out[4] [*8];
    endsequence
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside read slot");
    id_read_a: assert property (i_rd && i_addr == ADDR_ID |=>
        o_rdata == {16'h0, NCH_CODE, 3'h0, $past(i_cmp_fitted), CARD_TYPE}) else $error("identity word wrong");
    mode_read_a: assert property (i_rd && i_addr == ADDR_MODE |=>
        o_rdata == {17'h0, $past(i_channel_mode_switches)}) else $error("mode readback wrong");
    oe_mode_a: assert property (up_cnt_reg == 4'hf |-> o_chan_oe == mode_oe)
        else $error("output enable not from mode");
    oe_wait_a: assert property (up_cnt_reg < 4'h2 |-> o_chan_oe == 5'h00)
        else $error("output enabled before capture");
    pulse_high_a: assert property ($rose(o_chan_out[4]) |-> pulse_hi_s)
        else $error("pulse high time wrong");
    pulse_low_a: assert property ($fell(o_chan_out[4]) |-> pulse_lo_s)
        else $error("pulse low time too short");
    irq_clear_a: assert property ($fell(o_irq) |-> $past(i_wr, 2))
        else $error("interrupt dropped without a write");
endmodule // pcc_monitor

bind pcc_top pcc_monitor #(.PULSE_HALF_CYCLES(PULSE_HALF_CYCLES)) i_pcc_monitor (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_channel_mode_switches(i_channel_mode_switches), .i_cmp_fitted(i_cmp_fitted),
    .o_chan_out(o_chan_out), .o_chan_oe(o_chan_oe), .o_irq(o_irq));

// [dv/pcc_field.sv]
// Purpose: Dual pickup meter model on pair 0 pins
// Assumes: Kind 0 A leads, 1 B leads, 2 both pickups in step
// Notes:   Free running, period 32 clocks; pins change just after the edge
`timescale 1ns/100ps
module pcc_field (
    input  wire logic       i_clock,
    input  wire logic [1:0] i_kind,
    output wire logic [1:0] o_pins
);
    logic [4:0] ph_reg = 5'h00;
    logic [4:0] b_ph;
    // Quarter period offset gives quadrature
    assign b_ph = (i_kind == 2'h2) ? ph_reg : (i_kind == 2'h1) ? ph_reg + 5'h08 : ph_reg - 5'h08;
    assign o_pins = {b_ph < 5'h10, ph_reg < 5'h10};
    always @(posedge i_clock)
        ph_reg <= ph_reg + 5'h01;
endmodule // pcc_field

// [dv/pcc_top_bench.sv]
// Purpose: Self-checking bench for pcc_top
// Assumes: Ch0/1 pulse in, ch2 debounced status in, ch3 status out, ch4 pulse out
// Notes:   Counts shortened by parameters; meter period 32 clocks is 8 ms
`timescale 1ns/100ps
module pcc_top_bench;
    import pcc_pkg::*;
    localparam logic [14:0] MODES = {3'h3, 3'h2, 3'h4, 3'h1, 3'h1};
    logic              i_clock = 1'b0;
    logic              i_arst_n = 1'b0;
    logic [ADDR_W-1:0] i_addr = 8'h00;
    logic [31:0]       i_wdata = 32'h0;
    logic              i_wr = 1'b0;
    logic              i_rd = 1'b0;
    logic [19:0]       thr_sw = 20'h0;
    logic [2:0]        pin_b = 3'h0;
    logic [1:0]        kind = 2'h0;
    logic [1:0]        pin_f;
    logic [31:0]       o_rdata, d;
    logic [NCH-1:0]    o_chan_out, o_chan_oe;
    logic              o_irq, prev;
    int                seed = 89, n_errors = 0, n_compared = 0, n, k;
    always #25 i_clock = ~i_clock;
    pcc_top #(.DEB_CYCLES(8), .TICK_CYCLES(4), .REFRESH_CYCLES(64), .PULSE_HALF_CYCLES(16)) i_pcc_top (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_channel_mode_switches(MODES), .i_channel_threshold_switches(thr_sw),
        .i_cmp_fitted(1'b1), .i_chan_pin({pin_b, pin_f}), .o_chan_out(o_chan_out), .o_chan_oe(o_chan_oe),
        .o_irq(o_irq));
    pcc_field i_pcc_field (.i_clock(i_clock), .i_kind(kind), .o_pins(pin_f));
    function automatic logic [31:0] exp_id();
        return {16'h0, NCH_CODE, 3'h0, 1'b1, CARD_TYPE};
    endfunction
    task cyc(input int c);
        repeat (c) @(posedge i_clock);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
        @(posedge i_clock); i_wr <= 1'b0;
    endtask
    // Read data only stand in the slot after the strobe
    task rd(input logic [7:0] a);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clock); i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clock);
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task results;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge i_clock);
        n_errors++;
        results();
    end
    initial begin
        @(posedge i_clock); thr_sw <= 20'($random(seed));
        cyc(5); i_arst_n <= 1'b1; cyc(8);
        rd(ADDR_ID); chk(d, exp_id());
        rd(ADDR_MODE); chk(d, {17'h0, MODES});
        rd(ADDR_THRESH); chk(d, {12'h0, thr_sw});
        rd(ADDR_CUTOFF); chk(d, {16'h0, CUTOFF_RST});
        rd(8'h3c); chk(d, 32'h0);
        chk(o_chan_oe, 32'h18);
        for (k = 0; k < 4; k++) begin
            n = $random(seed); wr(ADDR_STAT_OUT, n); rd(ADDR_STAT_OUT);
            chk(d, {27'h0, n[4:0]}); chk(o_chan_out[3], n[3]);
        end
        n = 1 + ($random(seed) & 3); wr(8'h50, n); k = 0; prev = 1'b0;
        repeat ((n + 2) * 32) begin
            @(negedge i_clock); k += (o_chan_out[4] && !prev); prev = o_chan_out[4];
        end
        @(posedge i_clock); chk(k, n); rd(8'h50); chk(d, 32'h0);
        pin_b[0] <= 1'b1; cyc(30); rd(ADDR_IN_LEVEL); chk(d[2], 1);
        pin_b[0] <= 1'b0; cyc(4); rd(ADDR_IN_LEVEL); chk(d[2], 1);
        cyc(20); rd(ADDR_IN_LEVEL); chk(d[2], 0);
        wr(ADDR_CUTOFF, 10); cyc(1); wr(ADDR_IRQ_MASK, 4'hf); cyc(300); wr(ADDR_IRQ_STAT, 4'hf); cyc(100);
        rd(ADDR_IRQ_STAT); chk(d[1:0], 0);
        rd(ADDR_CMP_STAT); chk(d[5:0], 6'h19);
        rd(8'h60); n = d; cyc(62); rd(8'h60); chk(d - n, 2);
        kind <= 2'h1; cyc(300); rd(ADDR_CMP_STAT); chk(d[0], 0);
        kind <= 2'h2; cyc(300); rd(ADDR_IRQ_STAT); chk(d[0], 1); chk(o_irq, 1);
        wr(ADDR_IRQ_STAT, 1); cyc(40); rd(ADDR_IRQ_STAT); chk(d[0], 1);
        wr(ADDR_IRQ_MASK, 0); cyc(3); chk(o_irq, 0); wr(ADDR_IRQ_MASK, 4'hf);
        kind <= 2'h0; cyc(300); rd(ADDR_IRQ_STAT); chk(d[0], 1);
        wr(ADDR_IRQ_STAT, 4'hf); cyc(3); rd(ADDR_IRQ_STAT); chk(d[0], 0);
        wr(ADDR_CUTOFF, 0); kind <= 2'h2; cyc(300); rd(ADDR_IRQ_STAT); chk(d[0], 0);
        rd(ADDR_CMP_STAT); chk(d[2], 1); chk(d[0], 1);
        results();
    end
endmodule // pcc_top_bench
